// ### hpx_pkg.sv
// hot-plug expander manager: shared constants, types and register map
// assumes a 125 MHz device clock and 16-bit expanders on the master bus
package hpx_pkg;
	localparam int CLK_MHZ = 125;
	localparam int UPDATE_MS = 40;
	localparam int UPDATE_CYC = UPDATE_MS * 1000 * CLK_MHZ;
	localparam int SMB_KHZ = 100;
	localparam int QUARTER_CYC = (CLK_MHZ * 1000) / (4 * SMB_KHZ);
	localparam logic [11:0] OFS_ADDR = 12'h000;
	localparam logic [11:0] OFS_DEBUG = 12'h004;
	localparam logic [11:0] OFS_STATUS = 12'h008;
	localparam int SEL_BIT = 0;
	localparam int RELOAD_BIT = 1;
	localparam int TM_BIT = 2;
	localparam int NACK_BIT = 0;
	localparam int ARB_BIT = 1;
	localparam logic [7:0] CMD_IN = 8'h00;
	localparam logic [7:0] CMD_OUT = 8'h02;
	localparam logic [7:0] CMD_POL = 8'h04;
	localparam logic [7:0] CMD_DIR = 8'h06;
	localparam logic [15:0] OUT_MASK = 16'hf0f0;
	localparam logic [15:0] DIR_VAL = 16'h0f0f;
	localparam logic [2:0] WR_LAST = 3'h3;
	localparam logic [2:0] RD_RESTART = 3'h1;
	localparam logic [2:0] RD_LAST = 3'h4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_START = 4'h2,
		ST_BIT = 4'h4,
		ST_STOP = 4'h8
	} hpx_state_t;
	typedef struct packed {
		logic exp;
		logic rd;
		logic cfg;
		logic [6:0] addr;
		logic [7:0] cmd;
		logic [15:0] data;
	} hpx_txn_t;
endpackage : hpx_pkg

// ### hpx_expander_mgr.sv
// hot-plug expander manager: keeps two 16-bit expanders and the core hot-plug view aligned
// assumes coreOut and eepromDone on this clock; scl, sda and interrupts are async pins
// Contract
// - mismatch between expander and core view triggers transaction
// - hot reset defaults rewritten via mismatch path
// - output writes spaced one update period apart
// - interrupt triggers input read, rate limited
// - round robin service between expanders
// - transaction errors recorded in status register
// - select chooses expander; data shows its view
// - reload issues write and read to selected
// - test mode drives outputs from debug data
// - debug data write in test mode updates outputs
// - eeprom loaded addresses configure after reset
// - init data sampled when transaction starts
// - every hot-plug output change sent out
// - no output change on entering reset
// - expander zero slot a low, slot c high
// - expander one slot b low, slot d high
// - address write configures directions and outputs
// - config writes regs 2,4,6 then reads 0
// - no transaction before eeprom load finishes
//
// Added by the designer: register access over AXI4-Lite and the register offsets.
module hpx_expander_mgr #(
	parameter int UPDATE_CYCLES = hpx_pkg::UPDATE_CYC,
	parameter int QUARTER_CYCLES = hpx_pkg::QUARTER_CYC
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic eepromDone,
	input wire logic [1:0][15:0] coreOut,
	output logic [1:0][15:0] hpInView,
	input wire logic [1:0] expIntN,
	input wire logic sclIn,
	output logic sclOut,
	output logic sclOe,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe
);
	localparam int TW = $clog2(UPDATE_CYCLES + 1);
	localparam int QW = $clog2(QUARTER_CYCLES + 1);
	localparam logic [15:0] MASK = hpx_pkg::OUT_MASK;

	// pin synchronisers: scl, sda and both interrupt lines
	logic [3:0] syn1_ff, syn2_ff;
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			syn1_ff <= 4'hf;
			syn2_ff <= 4'hf;
		end else begin
			syn1_ff <= {sclIn, sdaIn, expIntN};
			syn2_ff <= syn1_ff;
		end
	end
	logic sclHi, sdaHi;
	logic [1:0] intAct;
	assign sclHi = syn2_ff[3];
	assign sdaHi = syn2_ff[2];
	assign intAct = ~syn2_ff[1:0]; // open-drain request, low active

	hpx_pkg::hpx_state_t st_ff, nxt_st;
	hpx_pkg::hpx_txn_t txn_ff, nxt_txn, lTxn;
	logic [1:0] ph_ff, nxt_ph, errT_ff, nxt_errT;
	logic [QW-1:0] qcnt_ff, nxt_qcnt;
	logic [3:0] bit_ff, nxt_bit;
	logic [2:0] idx_ff, nxt_idx;
	logic [7:0] sh_ff, nxt_sh;
	logic [15:0] rx_ff, nxt_rx, rxWord;
	logic sclOe_ff, nxt_sclOe, sdaOe_ff, nxt_sdaOe;
	logic launch, fin, qtick, rxByte, want, gExp, doWr;
	logic [1:0][6:0] expAddr_ff, nxt_expAddr;
	logic [1:0] expEn_ff, nxt_expEn, cfgPend_ff, nxt_cfgPend, rdPend_ff, nxt_rdPend;
	logic [1:0] wrForce_ff, nxt_wrForce, stat_ff, nxt_stat, mism, elig;
	logic [1:0][1:0] cfgStep_ff, nxt_cfgStep;
	logic [1:0][15:0] tmData_ff, nxt_tmData, shadow_ff, nxt_shadow, inView_ff, nxt_inView;
	logic [1:0][15:0] desired;
	logic [1:0][TW-1:0] tmr_ff, nxt_tmr;
	logic dbgSel_ff, nxt_dbgSel, dbgTm_ff, nxt_dbgTm, rr_ff, nxt_rr;
	// register bus write capture, read by the manager below
	logic [11:0] awAddr_ff, nxt_awAddr;
	logic [31:0] wData_ff, nxt_wData, rdata_ff, nxt_rdata, rdWord;
	logic [3:0] wStrb_ff, nxt_wStrb;

	// byte sent at position i of a frame
	function automatic logic [7:0] byteOf(input hpx_pkg::hpx_txn_t t, input logic [2:0] i);
		case (i)
			3'h0: byteOf = {t.addr, 1'b0};
			3'h1: byteOf = t.cmd;
			3'h2: byteOf = t.rd ? {t.addr, 1'b1} : t.data[7:0];
			default: byteOf = t.data[15:8];
		endcase
	endfunction : byteOf

	assign qtick = (qcnt_ff == '0) && (st_ff != hpx_pkg::ST_IDLE);
	assign rxByte = txn_ff.rd && (idx_ff >= 3'h3);
	// ack the first read byte, nack the last one
	assign want = (bit_ff < 4'h8) ? (rxByte | sh_ff[7]) : (!rxByte || idx_ff == hpx_pkg::RD_LAST);
	assign fin = qtick && (st_ff == hpx_pkg::ST_STOP) && (ph_ff == 2'h3);
	assign rxWord = {rx_ff[7:0], rx_ff[15:8]};

	// bus engine: four quarter phases per bit; released scl waits for stretching targets
	always_comb begin
		nxt_st = st_ff;
		nxt_ph = ph_ff;
		nxt_txn = txn_ff;
		nxt_errT = errT_ff;
		nxt_bit = bit_ff;
		nxt_idx = idx_ff;
		nxt_sh = sh_ff;
		nxt_rx = rx_ff;
		nxt_sclOe = sclOe_ff;
		nxt_sdaOe = sdaOe_ff;
		if (st_ff == hpx_pkg::ST_IDLE || qtick)
			nxt_qcnt = QW'(QUARTER_CYCLES - 1);
		else if (!sclOe_ff && !sclHi)
			nxt_qcnt = qcnt_ff;
		else
			nxt_qcnt = qcnt_ff - 1'b1;
		if (launch) begin
			nxt_st = hpx_pkg::ST_START;
			nxt_ph = 2'h0;
			nxt_txn = lTxn;
			nxt_idx = 3'h0;
			nxt_errT = 2'h0;
		end else if (qtick) begin
			nxt_ph = ph_ff + 2'h1;
			case (st_ff)
				hpx_pkg::ST_START: begin
					if (ph_ff == 2'h0) nxt_sdaOe = 1'b0;
					if (ph_ff == 2'h1) nxt_sclOe = 1'b0;
					if (ph_ff == 2'h2) nxt_sdaOe = 1'b1;
					if (ph_ff == 2'h3) begin
						nxt_sclOe = 1'b1;
						nxt_st = hpx_pkg::ST_BIT;
						nxt_bit = 4'h0;
						nxt_sh = byteOf(txn_ff, idx_ff);
					end
				end
				hpx_pkg::ST_BIT: begin
					if (ph_ff == 2'h0) nxt_sdaOe = !want;
					if (ph_ff == 2'h1) nxt_sclOe = 1'b0;
					if (ph_ff == 2'h2) begin
						if (bit_ff < 4'h8 && rxByte) nxt_rx = {rx_ff[14:0], sdaHi};
						if (bit_ff < 4'h8 && !rxByte && want && !sdaHi)
							nxt_errT[hpx_pkg::ARB_BIT] = 1'b1;
						if (bit_ff == 4'h8 && !rxByte && sdaHi)
							nxt_errT[hpx_pkg::NACK_BIT] = 1'b1;
					end
					if (ph_ff == 2'h3) begin
						nxt_sclOe = 1'b1;
						nxt_bit = bit_ff + 4'h1;
						nxt_sh = {sh_ff[6:0], 1'b0};
						if (bit_ff == 4'h8) begin
							nxt_bit = 4'h0;
							nxt_idx = idx_ff + 3'h1;
							nxt_sh = byteOf(txn_ff, idx_ff + 3'h1);
							// an error ends the frame at the byte boundary
							if (errT_ff != 2'h0 ||
									idx_ff == (txn_ff.rd ? hpx_pkg::RD_LAST : hpx_pkg::WR_LAST))
								nxt_st = hpx_pkg::ST_STOP;
							else if (txn_ff.rd && idx_ff == hpx_pkg::RD_RESTART)
								nxt_st = hpx_pkg::ST_START;
						end
					end
				end
				hpx_pkg::ST_STOP: begin
					if (ph_ff == 2'h0) nxt_sdaOe = 1'b1;
					if (ph_ff == 2'h1) nxt_sclOe = 1'b0;
					if (ph_ff == 2'h2) nxt_sdaOe = 1'b0;
					if (ph_ff == 2'h3) nxt_st = hpx_pkg::ST_IDLE;
				end
				default: nxt_st = hpx_pkg::ST_IDLE;
			endcase
		end
	end

	// reset releases both lines and leaves expander outputs untouched
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			st_ff <= hpx_pkg::ST_IDLE;
			ph_ff <= 2'h0;
			txn_ff <= '0;
			errT_ff <= 2'h0;
			qcnt_ff <= '0;
			bit_ff <= 4'h0;
			idx_ff <= 3'h0;
			sh_ff <= 8'h00;
			rx_ff <= 16'h0000;
			sclOe_ff <= 1'b0;
			sdaOe_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			ph_ff <= nxt_ph;
			txn_ff <= nxt_txn;
			errT_ff <= nxt_errT;
			qcnt_ff <= nxt_qcnt;
			bit_ff <= nxt_bit;
			idx_ff <= nxt_idx;
			sh_ff <= nxt_sh;
			rx_ff <= nxt_rx;
			sclOe_ff <= nxt_sclOe;
			sdaOe_ff <= nxt_sdaOe;
		end
	end

	// per expander wanted outputs, mismatch and eligibility
	for (genvar e = 0; e < 2; e++) begin : g_exp
		assign desired[e] = ((dbgTm_ff && dbgSel_ff == 1'(e)) ? tmData_ff[e] : coreOut[e])
			& MASK;
		assign mism[e] = expEn_ff[e] && (desired[e] != shadow_ff[e]);
		// requests stay pending while the period runs out
		assign elig[e] = expEn_ff[e] && (tmr_ff[e] == '0) && (cfgPend_ff[e] || mism[e] ||
			wrForce_ff[e] || rdPend_ff[e] || intAct[e]);
	end
	assign gExp = elig[rr_ff] ? rr_ff : !rr_ff;
	assign launch = eepromDone && (st_ff == hpx_pkg::ST_IDLE) && (elig != 2'h0);

	// next transaction: configuration steps first, then output write, then input read
	always_comb begin
		lTxn.exp = gExp;
		lTxn.rd = 1'b0;
		lTxn.cfg = cfgPend_ff[gExp];
		lTxn.addr = expAddr_ff[gExp];
		lTxn.cmd = hpx_pkg::CMD_OUT;
		lTxn.data = desired[gExp]; // values at issue time
		if (cfgPend_ff[gExp]) begin
			case (cfgStep_ff[gExp])
				2'h0: lTxn.cmd = hpx_pkg::CMD_OUT;
				2'h1: begin
					lTxn.cmd = hpx_pkg::CMD_POL;
					lTxn.data = 16'h0000;
				end
				2'h2: begin
					lTxn.cmd = hpx_pkg::CMD_DIR;
					lTxn.data = hpx_pkg::DIR_VAL;
				end
				default: begin
					lTxn.rd = 1'b1;
					lTxn.cmd = hpx_pkg::CMD_IN;
					lTxn.data = 16'h0000;
				end
			endcase
		end else if (!mism[gExp] && !wrForce_ff[gExp]) begin
			lTxn.rd = 1'b1;
			lTxn.cmd = hpx_pkg::CMD_IN;
			lTxn.data = 16'h0000;
		end
	end

	// manager state; software sets are applied after completion so they win
	always_comb begin
		nxt_expAddr = expAddr_ff;
		nxt_expEn = expEn_ff;
		nxt_cfgPend = cfgPend_ff;
		nxt_cfgStep = cfgStep_ff;
		nxt_rdPend = rdPend_ff;
		nxt_wrForce = wrForce_ff;
		nxt_tmData = tmData_ff;
		nxt_shadow = shadow_ff;
		nxt_inView = inView_ff;
		nxt_dbgSel = dbgSel_ff;
		nxt_dbgTm = dbgTm_ff;
		nxt_rr = rr_ff;
		nxt_stat = stat_ff;
		for (int e = 0; e < 2; e++) begin
			if (launch && gExp == 1'(e))
				nxt_tmr[e] = TW'(UPDATE_CYCLES - 1);
			else if (tmr_ff[e] != '0)
				nxt_tmr[e] = tmr_ff[e] - 1'b1;
			else
				nxt_tmr[e] = tmr_ff[e];
		end
		if (launch) nxt_rr = !gExp;
		// a reload landing during a running read still gets a read of its own
		if (launch && lTxn.rd && !lTxn.cfg) nxt_rdPend[gExp] = 1'b0;
		if (doWr && awAddr_ff == hpx_pkg::OFS_STATUS && wStrb_ff[0])
			nxt_stat = stat_ff & ~wData_ff[1:0];
		if (fin) begin
			if (errT_ff != 2'h0) begin
				nxt_stat = nxt_stat | errT_ff; // retried after the next period
				if (txn_ff.rd && !txn_ff.cfg) nxt_rdPend[txn_ff.exp] = 1'b1;
			end else begin
				if (!txn_ff.rd && txn_ff.cmd == hpx_pkg::CMD_OUT) begin
					nxt_shadow[txn_ff.exp] = txn_ff.data;
					nxt_wrForce[txn_ff.exp] = 1'b0;
				end
				if (txn_ff.rd) nxt_inView[txn_ff.exp] = rxWord;
				if (txn_ff.cfg) begin
					nxt_cfgStep[txn_ff.exp] = cfgStep_ff[txn_ff.exp] + 2'h1;
					if (txn_ff.rd) nxt_cfgPend[txn_ff.exp] = 1'b0;
				end
			end
		end
		if (doWr && awAddr_ff == hpx_pkg::OFS_ADDR) begin
			for (int e = 0; e < 2; e++) begin
				if (wStrb_ff[e]) begin
					nxt_expAddr[e] = wData_ff[8*e +: 7];
					nxt_expEn[e] = wData_ff[8*e+7];
					nxt_cfgPend[e] = 1'b1;
					nxt_cfgStep[e] = 2'h0;
				end
			end
		end
		if (doWr && awAddr_ff == hpx_pkg::OFS_DEBUG) begin
			if (wStrb_ff[0]) begin
				nxt_dbgSel = wData_ff[hpx_pkg::SEL_BIT];
				nxt_dbgTm = wData_ff[hpx_pkg::TM_BIT];
				if (wData_ff[hpx_pkg::RELOAD_BIT]) begin
					nxt_rdPend[nxt_dbgSel] = 1'b1;
					nxt_wrForce[nxt_dbgSel] = 1'b1;
				end
			end
			if (wStrb_ff[2]) nxt_tmData[nxt_dbgSel][7:0] = wData_ff[23:16];
			if (wStrb_ff[3]) nxt_tmData[nxt_dbgSel][15:8] = wData_ff[31:24];
		end
	end

	// manager registers
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			expAddr_ff <= '0;
			expEn_ff <= 2'h0;
			cfgPend_ff <= 2'h0;
			cfgStep_ff <= '0;
			rdPend_ff <= 2'h0;
			wrForce_ff <= 2'h0;
			tmData_ff <= '0;
			shadow_ff <= '0;
			inView_ff <= '0;
			tmr_ff <= '0;
			dbgSel_ff <= 1'b0;
			dbgTm_ff <= 1'b0;
			rr_ff <= 1'b0;
			stat_ff <= 2'h0;
		end else begin
			expAddr_ff <= nxt_expAddr;
			expEn_ff <= nxt_expEn;
			cfgPend_ff <= nxt_cfgPend;
			cfgStep_ff <= nxt_cfgStep;
			rdPend_ff <= nxt_rdPend;
			wrForce_ff <= nxt_wrForce;
			tmData_ff <= nxt_tmData;
			shadow_ff <= nxt_shadow;
			inView_ff <= nxt_inView;
			tmr_ff <= nxt_tmr;
			dbgSel_ff <= nxt_dbgSel;
			dbgTm_ff <= nxt_dbgTm;
			rr_ff <= nxt_rr;
			stat_ff <= nxt_stat;
		end
	end

	// axi4-lite slave: address and data taken in either order, one answer each
	logic awHeld_ff, nxt_awHeld, wHeld_ff, nxt_wHeld, bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
	logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp, rdResp;
	logic [15:0] viewSel;
	assign doWr = awHeld_ff && wHeld_ff && !bvalid_ff;
	assign viewSel = shadow_ff[dbgSel_ff] | (inView_ff[dbgSel_ff] & ~MASK);
	always_comb begin
		rdWord = 32'h0000_0000;
		rdResp = hpx_pkg::RESP_OKAY;
		case (s_axi_araddr)
			hpx_pkg::OFS_ADDR: rdWord = {16'h0000, expEn_ff[1], expAddr_ff[1],
				expEn_ff[0], expAddr_ff[0]};
			hpx_pkg::OFS_DEBUG: rdWord = {viewSel, 13'h0000, dbgTm_ff, 1'b0, dbgSel_ff};
			hpx_pkg::OFS_STATUS: rdWord = {23'h000000, st_ff != hpx_pkg::ST_IDLE, 6'h00, stat_ff};
			default: rdResp = hpx_pkg::RESP_SLVERR;
		endcase
		nxt_awHeld = awHeld_ff;
		nxt_awAddr = awAddr_ff;
		nxt_wHeld = wHeld_ff;
		nxt_wData = wData_ff;
		nxt_wStrb = wStrb_ff;
		nxt_bvalid = bvalid_ff;
		nxt_bresp = bresp_ff;
		nxt_rvalid = rvalid_ff;
		nxt_rdata = rdata_ff;
		nxt_rresp = rresp_ff;
		if (s_axi_awvalid && !awHeld_ff) begin
			nxt_awHeld = 1'b1;
			nxt_awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !wHeld_ff) begin
			nxt_wHeld = 1'b1;
			nxt_wData = s_axi_wdata;
			nxt_wStrb = s_axi_wstrb;
		end
		if (bvalid_ff && s_axi_bready) nxt_bvalid = 1'b0;
		if (doWr) begin
			nxt_awHeld = 1'b0;
			nxt_wHeld = 1'b0;
			nxt_bvalid = 1'b1;
			nxt_bresp = (awAddr_ff == hpx_pkg::OFS_ADDR || awAddr_ff == hpx_pkg::OFS_DEBUG ||
				awAddr_ff == hpx_pkg::OFS_STATUS) ? hpx_pkg::RESP_OKAY : hpx_pkg::RESP_SLVERR;
		end
		if (s_axi_arvalid && !rvalid_ff) begin
			nxt_rvalid = 1'b1;
			nxt_rdata = rdWord;
			nxt_rresp = rdResp;
		end else if (rvalid_ff && s_axi_rready)
			nxt_rvalid = 1'b0;
	end
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			awHeld_ff <= 1'b0;
			awAddr_ff <= 12'h000;
			wHeld_ff <= 1'b0;
			wData_ff <= 32'h0000_0000;
			wStrb_ff <= 4'h0;
			bvalid_ff <= 1'b0;
			bresp_ff <= 2'h0;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= 2'h0;
		end else begin
			awHeld_ff <= nxt_awHeld;
			awAddr_ff <= nxt_awAddr;
			wHeld_ff <= nxt_wHeld;
			wData_ff <= nxt_wData;
			wStrb_ff <= nxt_wStrb;
			bvalid_ff <= nxt_bvalid;
			bresp_ff <= nxt_bresp;
			rvalid_ff <= nxt_rvalid;
			rdata_ff <= nxt_rdata;
			rresp_ff <= nxt_rresp;
		end
	end

	// outputs; open-drain lines only ever pull low
	assign s_axi_awready = !awHeld_ff;
	assign s_axi_wready = !wHeld_ff;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
	assign hpInView = inView_ff;
	assign sclOut = 1'b0;
	assign sdaOut = 1'b0;
	assign sclOe = sclOe_ff;
	assign sdaOe = sdaOe_ff;

	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	chk_ee_gate: assert property ((st_ff == hpx_pkg::ST_IDLE) ##1 (st_ff == hpx_pkg::ST_START)
		|-> $past(eepromDone))
		else $error("frame started before eeprom load done");
	chk_timer_restart: assert property ((launch && !gExp) |=> tmr_ff[0] == TW'(UPDATE_CYCLES - 1))
		else $error("update timer not restarted");
	chk_rate_limit: assert property (launch |-> tmr_ff[gExp] == '0)
		else $error("transaction inside update period");
	chk_rr_fair: assert property ((launch && elig == 2'h3) |-> (gExp == rr_ff) ##1 (rr_ff != $past(rr_ff)))
		else $error("round robin order broken");
	chk_err_record: assert property ((fin && errT_ff[0]) |=> stat_ff[0])
		else $error("nack not recorded");
	chk_shadow_upd: assert property ((fin && errT_ff == 2'h0 && !txn_ff.rd &&
		txn_ff.cmd == hpx_pkg::CMD_OUT) |=> shadow_ff[$past(txn_ff.exp)] == $past(txn_ff.data))
		else $error("output view not updated");
	chk_read_view: assert property ((fin && errT_ff == 2'h0 && txn_ff.rd)
		|=> inView_ff[$past(txn_ff.exp)] == $past(rxWord))
		else $error("input view not updated");
	chk_test_data: assert property ((launch && dbgTm_ff && gExp == dbgSel_ff && !lTxn.rd &&
		lTxn.cmd == hpx_pkg::CMD_OUT) |-> lTxn.data == (tmData_ff[gExp] & MASK))
		else $error("test mode data not used");
	chk_cfg_dir: assert property ((launch && lTxn.cfg && cfgStep_ff[gExp] == 2'h2)
		|-> lTxn.cmd == hpx_pkg::CMD_DIR && lTxn.data == hpx_pkg::DIR_VAL)
		else $error("direction step wrong");
	chk_reload_req: assert property ((doWr && awAddr_ff == hpx_pkg::OFS_DEBUG && wStrb_ff[0] &&
		wData_ff[1]) |=> rdPend_ff[$past(wData_ff[0])] && wrForce_ff[$past(wData_ff[0])])
		else $error("reload not requested");
	// the default disable would mask every reset cycle, so this one opts out
	chk_reset_quiet: assert property (@(posedge clock) disable iff (1'b0)
		sys_rst |=> !sclOe && !sdaOe)
		else $error("bus driven after reset");
	cov_write: cover property (fin && !txn_ff.rd && errT_ff == 2'h0);
	cov_read: cover property (fin && txn_ff.rd && errT_ff == 2'h0);
	cov_error: cover property (fin && errT_ff != 2'h0);
	cov_contend: cover property (launch && elig == 2'h3);
endmodule : hpx_expander_mgr

// ### hpx_exp_model.sv
// expander model: one 16-bit port expander on the shared two-wire bus
// assumes resolved scl/sda levels with pull-ups; it only ever pulls sda low
module hpx_exp_model #(
	parameter logic [6:0] ADDR = 7'h20
) (
	input wire logic scl,
	input wire logic sda,
	input wire logic [15:0] pins,
	output logic pullSda,
	output logic intN
);
	timeunit 1ns;
	timeprecision 1ps;
	// power-up values differ from the configured ones so a skipped step shows
	logic [15:0] outR = 16'hffff, polR = 16'hffff, dirR = 16'hffff, lastRd = 16'h0000;
	logic [15:0] inVal;
	logic [7:0] sh = 8'h00, cmd = 8'h00;
	logic act = 1'b0, rd = 1'b0;
	int n = 0, b = 0;
	initial pullSda = 1'b0;
	assign inVal = (pins & dirR) | (outR & ~dirR);
	// request while any input pin differs from the value last read
	assign intN = ~|((inVal ^ lastRd) & dirR);
	// start or repeated start restarts byte framing
	always @(negedge sda) if (scl) begin
		n = 0;
		b = 0;
		act = 1'b0;
	end
	// stop releases the device
	always @(posedge sda) if (scl) act = 1'b0;
	// shift in address, command and write bytes
	always @(posedge scl) begin
		if (n < 8) sh = {sh[6:0], sda};
		if (n == 7 && b == 0) begin
			act = (sh[7:1] == ADDR);
			rd = sh[0];
		end else if (n == 7 && act && !rd && b == 1) cmd = sh;
		else if (n == 7 && act && !rd) begin
			case (3'(cmd + b - 2))
				3'h2: outR[7:0] = sh;
				3'h3: outR[15:8] = sh;
				3'h4: polR[7:0] = sh;
				3'h5: polR[15:8] = sh;
				3'h6: dirR[7:0] = sh;
				3'h7: dirR[15:8] = sh;
				default: ;
			endcase
		end
		n = (n == 8) ? 0 : n + 1;
		if (n == 0) b++;
	end
	// ack and read data change only while scl is low
	always @(negedge scl) begin
		pullSda = 1'b0;
		if (act && n == 8 && (!rd || b == 0)) pullSda = 1'b1;
		else if (act && rd && b > 0 && b < 3 && n < 8) begin
			if (b == 1 && n == 0) lastRd = inVal;
			pullSda = ~inVal[8 * (b - 1) + 7 - n];
		end
	end
endmodule : hpx_exp_model

// ### hpx_expander_mgr_tb.sv
// bench for the hot-plug expander manager: register tasks and two expander models
// assumes shortened update and bit periods handed in through the parameters
module hpx_expander_mgr_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int UPD = 200;
	logic clock = 1'b0, sys_rst = 1'b1, eepromDone = 1'b0, seen = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	wire logic [1:0] expIntN, pull;
	logic [1:0][15:0] coreOut = 32'h0, pins = 32'h0, hpInView;
	logic sclOut, sclOe, sdaOut, sdaOe, scl, sda;
	int err_total = 0, checks_done = 0, cyc = 0;
	// open-drain lines with pull-ups
	assign scl = ~sclOe;
	assign sda = ~(sdaOe | pull[0] | pull[1]);
	initial forever #4 clock = ~clock;
	hpx_expander_mgr #(.UPDATE_CYCLES(UPD), .QUARTER_CYCLES(4)) dut (.clock(clock),
		.sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.eepromDone(eepromDone), .coreOut(coreOut), .hpInView(hpInView),
		.expIntN(expIntN), // interrupt pins routed as alternate function
		.sclIn(scl), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe));
	hpx_exp_model #(.ADDR(7'h20)) m0 (.scl(scl), .sda(sda), .pins(pins[0]), .pullSda(pull[0]),
		.intN(expIntN[0]));
	hpx_exp_model #(.ADDR(7'h21)) m1 (.scl(scl), .sda(sda), .pins(pins[1]), .pullSda(pull[1]),
		.intN(expIntN[1]));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	// one write; each channel released once taken, response waited for
	task automatic axiWr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// waits for bvalid with no timeout of its own; only the bench's cycle limit bounds it
		do begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		chk(32'(s_axi_bresp), 32'(hpx_pkg::RESP_OKAY));
		s_axi_bready <= 1'b0;
	endtask : axiWr
	task automatic axiRd(input logic [11:0] a);
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clock);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axiRd
	// bus counts as settled after a long stretch with both lines released
	task automatic settle();
		int q;
		q = 0;
		for (int t = 0; t < 30000 && q < 700; t++) begin
			@(posedge clock);
			q = (sclOe || sdaOe) ? 0 : q + 1;
		end
		chk(32'(q >= 700), 32'h1);
	endtask : settle
	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : report_and_stop
	// frame watch and run limit well above the expected length
	always @(posedge clock) begin
		cyc++;
		if (sclOe === 1'b1) seen <= 1'b1;
		if (cyc == 90000) begin
			err_total++;
			report_and_stop();
		end
	end
	initial begin
		repeat (8) @(posedge clock);
		sys_rst <= 1'b0;
		axiRd(hpx_pkg::OFS_STATUS);
		chk(rd, 32'h0);
		axiRd(12'h010);
		chk(32'(rsp), 32'(hpx_pkg::RESP_SLVERR));
		coreOut <= {16'h5050, 16'h90a0};
		axiWr(hpx_pkg::OFS_ADDR, 32'h0000a1a0);
		repeat (1000) @(posedge clock);
		chk(32'(seen), 32'h0);
		eepromDone <= 1'b1;
		settle();
		chk(32'(m0.dirR), 32'h0f0f);
		chk(32'(m1.polR), 32'h0);
		chk(32'(m0.outR & 16'hf0f0), 32'h90a0);
		chk(32'(m1.outR & 16'hf0f0), 32'h5050);
		// second change lands inside the period and must still go out
		coreOut <= {16'h00f0, 16'h6030};
		repeat (20) @(posedge clock);
		coreOut[0] <= 16'hc0f0;
		settle();
		chk(32'(m0.outR & 16'hf0f0), 32'hc0f0);
		chk(32'(m1.outR & 16'hf0f0), 32'h00f0);
		pins[1] <= 16'h0a05;
		repeat (10) @(posedge clock);
		chk(32'(expIntN[1]), 32'h0);
		settle();
		chk(32'(hpInView[1] & 16'h0f0f), 32'h0a05);
		chk(32'(expIntN[1]), 32'h1);
		axiWr(hpx_pkg::OFS_DEBUG, 32'h1);
		axiRd(hpx_pkg::OFS_DEBUG);
		chk(32'(rd[31:16]), 32'h0af5);
		pins[0] <= 16'h0003;
		axiWr(hpx_pkg::OFS_DEBUG, 32'h2);
		settle();
		axiRd(hpx_pkg::OFS_DEBUG);
		chk(32'(rd[31:16]), 32'hc0f3);
		axiWr(hpx_pkg::OFS_DEBUG, 32'h50900004);
		settle();
		chk(32'(m0.outR & 16'hf0f0), 32'h5090);
		axiWr(hpx_pkg::OFS_DEBUG, 32'h0);
		settle();
		chk(32'(m0.outR & 16'hf0f0), 32'hc0f0);
		// nobody answers at this address, so the frame is refused
		axiWr(hpx_pkg::OFS_ADDR, 32'h0000b3a0);
		rd = 32'h0;
		for (int i = 0; i < 100 && rd[0] !== 1'b1; i++) begin
			repeat (50) @(posedge clock);
			axiRd(hpx_pkg::OFS_STATUS);
		end
		chk(32'(rd[0]), 32'h1);
		axiWr(hpx_pkg::OFS_ADDR, 32'h000000a0);
		settle();
		axiWr(hpx_pkg::OFS_STATUS, 32'h3);
		axiRd(hpx_pkg::OFS_STATUS);
		chk(32'(rd[1:0]), 32'h0);
		seen <= 1'b0;
		sys_rst <= 1'b1;
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		repeat (1000) @(posedge clock);
		chk(32'(seen), 32'h0);
		chk(32'(m0.outR & 16'hf0f0), 32'hc0f0);
		report_and_stop();
	end
endmodule : hpx_expander_mgr_tb
